//--- hw/msp_uart.sv
// Purpose: serial port with shift mode and three UART modes, AHB-Lite regs
// Assumes: sys_clk is the core clock; timer 1 overflow is a same-clock pulse
// Notes  : zero wait state slave; mode 0 transmit drives data on the two-way pin
`timescale 1ns/1ps
`include "msp_defs.svh"
module msp_uart (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // register bus
   input  wire msp_pkg::msp_ahb_req_t ahbReq,
   output msp_pkg::msp_ahb_rsp_t      ahbRsp,
   // baud source from timer 1
   input  wire logic                  t1Overflow,
   // serial pins
   input  wire logic                  rxdIn,
   output msp_pkg::msp_ser_out_t      serOut
);
   import msp_pkg::*;

   localparam msp_state_t RST_STATE = '{
      ctrl:    `MSP_RST_CTRL,
      rxBuf:   `MSP_RST_DATA,
      relLow:  `MSP_RST_RELL,
      relHigh: `MSP_RST_RELH,
      bdSel:   `MSP_RST_BSEL,
      smod:    `MSP_RST_PWR,
      rsp:     '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0},
      out:     '{txd: 1'b1, rxdOut: 1'b1, rxdOe_n: 1'b1},
      rxS1:    1'b1,
      rxS2:    1'b1,
      rxPrev:  1'b1,
      txSt:    MSP_TX_IDLE,
      rxSt:    MSP_RX_IDLE,
      default: '0
   };

   msp_state_t s;
   msp_state_t next_s;
   msp_mode_t  mode;

   // outputs come straight from the state register
   assign ahbRsp = s.rsp;
   assign serOut = s.out;
   assign mode   = msp_mode_t'(s.ctrl[7:6]);

   // whole next-state computation
   always_comb begin
      logic [7:0]  idx;
      logic        mapped;
      logic [7:0]  rdVal;
      logic [7:0]  wData;
      logic        startTx;
      logic [9:0]  relValue;
      logic        relOvf;
      logic        src;
      logic [1:0]  preLast;
      logic        tick;
      logic        ninthTx;
      logic        ninthRx;
      logic        keep;
      logic [10:0] shifted;
      next_s   = s;
      idx      = ahbReq.haddr[9:2];
      mapped   = (ahbReq.haddr[31:10] == 22'h0) &&
                 (ahbReq.haddr[1:0] == 2'h0);
      rdVal    = 8'h00;
      wData    = ahbReq.hwdata[7:0];
      startTx  = 1'b0;
      relValue = {s.relHigh[1:0], s.relLow};
      relOvf   = 1'b0;
      src      = 1'b0;
      preLast  = 2'h0;
      tick     = 1'b0;
      ninthTx  = 1'b1;
      ninthRx  = 1'b0;
      keep     = 1'b0;
      shifted  = 11'h0;

      // read mux; unmapped addresses and the low seven bits of BSEL and PWR read as zero
      case (idx)
         `MSP_IDX_CTRL: rdVal = s.ctrl;
         `MSP_IDX_DATA: rdVal = s.rxBuf;
         `MSP_IDX_RELL: rdVal = s.relLow;
         `MSP_IDX_RELH: rdVal = s.relHigh;
         `MSP_IDX_BSEL: rdVal = {s.bdSel, 7'h00};
         `MSP_IDX_PWR:  rdVal = {s.smod, 7'h00};
         default:       rdVal = 8'h00;
      endcase
      if (!mapped) begin
         rdVal = 8'h00;
      end

      // address phase: reads answer now, writes wait for their data
      next_s.wrPend = 1'b0;
      if (ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready) begin
         if (ahbReq.hwrite) begin
            next_s.wrPend = mapped;
            next_s.wrIdx  = idx;
         end else begin
            next_s.rsp.hrdata = {24'h000000, rdVal};
         end
      end

      // data phase of a write; hardware updates below override it
      if (s.wrPend) begin
         case (s.wrIdx)
            `MSP_IDX_CTRL: next_s.ctrl    = wData;
            `MSP_IDX_DATA: startTx        = 1'b1;
            `MSP_IDX_RELL: next_s.relLow  = wData;
            `MSP_IDX_RELH: next_s.relHigh = wData;
            `MSP_IDX_BSEL: next_s.bdSel   = wData[7];
            `MSP_IDX_PWR:  next_s.smod    = wData[7];
            default:       next_s.wrPend  = 1'b0;
         endcase
      end

      // reload counter: one overflow every 1024 - reload clocks
      if (s.relCnt == `MSP_REL_TOP) begin
         next_s.relCnt = relValue;
         relOvf        = 1'b1;
      end else begin
         next_s.relCnt = s.relCnt + 10'h001;
      end

      // 16x oversampling tick; every source is clocked by sys_clk
      if (mode == MSP_MODE_UART9F) begin
         src     = 1'b1;
         preLast = s.smod ? 2'h1 : 2'h3;
      end else if (s.bdSel) begin
         src     = relOvf;
         preLast = s.smod ? 2'h1 : 2'h3;
      end else begin
         // timer overflow source is kept but its rate is software's
         src     = t1Overflow;
         preLast = s.smod ? 2'h0 : 2'h1;
      end
      if (src) begin
         // >= recovers at once if the doubling flag shrinks preLast
         if (s.pre >= preLast) begin
            next_s.pre = 2'h0;
            tick       = 1'b1;
         end else begin
            next_s.pre = s.pre + 2'h1;
         end
      end

      // receive pin synchroniser; logic reads the second stage and rxPrev, its copy one clock later
      next_s.rxS1   = rxdIn;
      next_s.rxS2   = s.rxS1;
      next_s.rxPrev = s.rxS2;

      // transmit engine, also runs the mode 0 receive shifter
      unique case (s.txSt)
         MSP_TX_IDLE: begin
            next_s.out.txd = 1'b1;
         end
         MSP_TX_SHIFT: begin
            next_s.m0Cnt = s.m0Cnt + 4'h1;
            if (s.m0Cnt == `MSP_M0_MID) begin
               // rising shift clock; data sampled here
               next_s.out.txd = 1'b1;
               if (s.m0Rx) begin
                  next_s.rxShift = {1'b0, s.rxS2, s.rxShift[7:1]};
               end
            end
            if (s.m0Cnt == `MSP_M0_LAST) begin
               next_s.m0Cnt   = 4'h0;
               next_s.txShift = {1'b1, s.txShift[10:1]};
               next_s.txLeft  = s.txLeft - 4'h1;
               if (s.txLeft == 4'h1) begin
                  next_s.txSt        = MSP_TX_IDLE;
                  next_s.out.rxdOe_n = 1'b1;
                  next_s.out.rxdOut  = 1'b1;
                  if (s.m0Rx) begin
                     next_s.rxBuf            = s.rxShift[7:0];
                     next_s.ctrl[`MSP_B_RI] = 1'b1;
                  end else begin
                     next_s.ctrl[`MSP_B_TI] = 1'b1;
                  end
               end else begin
                  next_s.out.txd    = 1'b0;
                  next_s.out.rxdOut = s.txShift[1];
               end
            end
         end
         MSP_TX_FRAME: begin
            if (tick) begin
               next_s.txPh = s.txPh + 4'h1;
               if (s.txPh == `MSP_OVS_LAST) begin
                  shifted        = {1'b1, s.txShift[10:1]};
                  next_s.txShift = shifted;
                  next_s.txLeft  = s.txLeft - 4'h1;
                  next_s.out.txd = shifted[0];
                  if (s.txLeft == 4'h2) begin
                     // stop bit begins now
                     next_s.ctrl[`MSP_B_TI] = 1'b1;
                  end
                  if (s.txLeft == 4'h1) begin
                     next_s.txSt    = MSP_TX_IDLE;
                     next_s.out.txd = 1'b1;
                  end
               end
            end
         end
         default: begin
            next_s.txSt = MSP_TX_IDLE;
         end
      endcase

      // a buffer write restarts the transmitter whatever it was doing
      if (startTx) begin
         next_s.txPh  = 4'h0;
         next_s.m0Cnt = 4'h0;
         if (mode == MSP_MODE_SHIFT) begin
            next_s.txSt        = MSP_TX_SHIFT;
            next_s.m0Rx        = 1'b0;
            next_s.txShift     = {3'h7, wData};
            next_s.txLeft      = 4'h8;
            next_s.out.txd     = 1'b0;
            next_s.out.rxdOut  = wData[0];
            next_s.out.rxdOe_n = 1'b0;
         end else begin
            if (mode != MSP_MODE_UART8) begin
               ninthTx = s.ctrl[`MSP_B_TB8];
            end
            next_s.txSt        = MSP_TX_FRAME;
            next_s.txShift     = {1'b1, ninthTx, wData, 1'b0};
            next_s.txLeft      = (mode == MSP_MODE_UART8) ? 4'ha : 4'hb;
            next_s.out.txd     = 1'b0;
            next_s.out.rxdOe_n = 1'b1;
            next_s.out.rxdOut  = 1'b1;
         end
      end else if (s.txSt == MSP_TX_IDLE && mode == MSP_MODE_SHIFT &&
                   s.ctrl[`MSP_B_REN] && !s.ctrl[`MSP_B_RI]) begin
         // mode 0 reception: we clock, the far end drives data
         next_s.txSt        = MSP_TX_SHIFT;
         next_s.m0Rx        = 1'b1;
         next_s.m0Cnt       = 4'h0;
         next_s.txLeft      = 4'h8;
         next_s.out.txd     = 1'b0;
         next_s.out.rxdOe_n = 1'b1;
      end

      // asynchronous receiver, held idle when disabled
      if (mode == MSP_MODE_SHIFT || !s.ctrl[`MSP_B_REN]) begin
         next_s.rxSt = MSP_RX_IDLE;
      end else begin
         unique case (s.rxSt)
            MSP_RX_IDLE: begin
               if (s.rxPrev && !s.rxS2) begin
                  next_s.rxSt = MSP_RX_START;
                  next_s.rxPh = 4'h0;
               end
            end
            MSP_RX_START: begin
               if (tick) begin
                  next_s.rxPh = s.rxPh + 4'h1;
                  if (s.rxPh == `MSP_OVS_MID) begin
                     // a glitch shorter than half a bit is dropped
                     if (!s.rxS2) begin
                        next_s.rxSt   = MSP_RX_DATA;
                        next_s.rxPh   = 4'h0;
                        next_s.rxLeft = (mode == MSP_MODE_UART8) ?
                                        4'h9 : 4'ha;
                     end else begin
                        next_s.rxSt = MSP_RX_IDLE;
                     end
                  end
               end
            end
            MSP_RX_DATA: begin
               if (tick) begin
                  next_s.rxPh = s.rxPh + 4'h1;
                  if (s.rxPh == `MSP_OVS_LAST) begin
                     if (s.rxLeft == 4'h1) begin
                        // middle of the stop bit
                        ninthRx = (mode == MSP_MODE_UART8) ?
                                  s.rxS2 : s.rxShift[8];
                        keep = !s.ctrl[`MSP_B_RI] &&
                               (!s.ctrl[`MSP_B_MPEN] || ninthRx);
                        if (keep) begin
                           next_s.rxBuf = (mode == MSP_MODE_UART8) ?
                                          s.rxShift[8:1] : s.rxShift[7:0];
                           next_s.ctrl[`MSP_B_RB8] = ninthRx;
                           next_s.ctrl[`MSP_B_RI]  = 1'b1;
                        end
                        next_s.rxSt = MSP_RX_IDLE;
                     end else begin
                        next_s.rxShift = {s.rxS2, s.rxShift[8:1]};
                        next_s.rxLeft  = s.rxLeft - 4'h1;
                     end
                  end
               end
            end
            default: begin
               next_s.rxSt = MSP_RX_IDLE;
            end
         endcase
      end
   end

   // single state register, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s <= RST_STATE;
      end else begin
         s <= next_s;
      end
   end
endmodule

//--- inc/msp_defs.svh
// Purpose: constants of the serial port block (offsets, fields, resets)
// Assumes: included by bare name from the design and the bench
// Notes  : offsets are register indices; byte address is index times four
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH
// register indices
`define MSP_IDX_CTRL  8'h98
`define MSP_IDX_DATA  8'h99
`define MSP_IDX_RELL  8'haa
`define MSP_IDX_RELH  8'hba
`define MSP_IDX_BSEL  8'hd8
`define MSP_IDX_PWR   8'h87
// reset values
`define MSP_RST_CTRL  8'h00
`define MSP_RST_DATA  8'h00
`define MSP_RST_RELL  8'hd9
`define MSP_RST_RELH  8'h03
`define MSP_RST_BSEL  1'h0
`define MSP_RST_PWR   1'h0
// serial_control field positions
`define MSP_B_MPEN    5
`define MSP_B_REN     4
`define MSP_B_TB8     3
`define MSP_B_RB8     2
`define MSP_B_TI      1
`define MSP_B_RI      0
// timing counts
`define MSP_M0_MID    4'h5
`define MSP_M0_LAST   4'hb
`define MSP_OVS_MID   4'h7
`define MSP_OVS_LAST  4'hf
`define MSP_REL_TOP   10'h3ff
`endif

//--- inc/msp_pkg.sv
// Purpose: types shared by the serial port block
// Assumes: constants come from msp_defs.svh
// Notes  : all state of the design is one packed struct
package msp_pkg;
   // serial_control mode_select encodings
   typedef enum logic [1:0] {
      MSP_MODE_SHIFT  = 2'b00,
      MSP_MODE_UART8  = 2'b01,
      MSP_MODE_UART9F = 2'b10,
      MSP_MODE_UART9V = 2'b11
   } msp_mode_t;
   typedef enum logic [1:0] {
      MSP_TX_IDLE  = 2'b00,
      MSP_TX_SHIFT = 2'b01,
      MSP_TX_FRAME = 2'b10
   } msp_tx_t;
   typedef enum logic [1:0] {
      MSP_RX_IDLE  = 2'b00,
      MSP_RX_START = 2'b01,
      MSP_RX_DATA  = 2'b10
   } msp_rx_t;
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } msp_ahb_req_t;
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } msp_ahb_rsp_t;
   typedef struct packed {
      logic txd;
      logic rxdOut;
      logic rxdOe_n;
   } msp_ser_out_t;
   typedef struct packed {
      logic [7:0]   ctrl;
      logic [7:0]   rxBuf;
      logic [7:0]   relLow;
      logic [7:0]   relHigh;
      logic         bdSel;
      logic         smod;
      logic         wrPend;
      logic [7:0]   wrIdx;
      msp_ahb_rsp_t rsp;
      msp_ser_out_t out;
      logic         rxS1;
      logic         rxS2;
      logic         rxPrev;
      logic [9:0]   relCnt;
      logic [1:0]   pre;
      logic [3:0]   m0Cnt;
      msp_tx_t      txSt;
      logic [10:0]  txShift;
      logic [3:0]   txLeft;
      logic [3:0]   txPh;
      logic         m0Rx;
      msp_rx_t      rxSt;
      logic [3:0]   rxPh;
      logic [3:0]   rxLeft;
      logic [8:0]   rxShift;
   } msp_state_t;
endpackage

//--- verif/msp_uart_monitor.sv
// Purpose: concurrent checks on the serial port ports
// Assumes: one clock domain, synchronous active-low reset
// Notes  : mode-0 counts assume no restart while a byte shifts
`timescale 1ns/1ps
module msp_uart_chk (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // register bus
   input  wire msp_pkg::msp_ahb_req_t ahbReq,
   input  wire msp_pkg::msp_ahb_rsp_t ahbRsp,
   // serial side
   input  wire logic                  t1Overflow,
   input  wire logic                  rxdIn,
   input  wire msp_pkg::msp_ser_out_t serOut
);
   import msp_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   logic [7:0] oeLow;
   logic       rdSeen;
   // counts driven cycles of the data pin; a plain repeat would unroll 96
   always_ff @(posedge sys_clk) begin
      if (!rst_n || serOut.rxdOe_n) oeLow <= 8'h00;
      else oeLow <= oeLow + 8'h01;
      rdSeen <= ahbReq.hsel && ahbReq.htrans[1] && !ahbReq.hwrite;
   end
   // data buffer write: address phase, then its data phase
   sequence s_dwr;
      ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hwrite && ahbReq.hready
      && ahbReq.haddr == 32'h264 ##1 1'b1;
   endsequence
   sequence s_rd;
      ahbReq.hsel && ahbReq.htrans[1] && !ahbReq.hwrite && ahbReq.hready;
   endsequence
   tx_start_a: assert property (s_dwr |=> !serOut.txd)
      else $error("transmit did not start after buffer write");
   m0_clock_a: assert property ($fell(serOut.txd) && !serOut.rxdOe_n
      |-> !serOut.txd [*6] ##1 serOut.txd)
      else $error("shift clock not six low then high");
   m0_len_a: assert property ($rose(serOut.rxdOe_n) |-> oeLow == 8'h60)
      else $error("shift transfer not 96 cycles");
   oe_start_a: assert property ($fell(serOut.rxdOe_n) |-> $fell(serOut.txd))
      else $error("data pin driven without shift clock");
   start_bit_a: assert property ($fell(serOut.txd) && serOut.rxdOe_n
      |-> !serOut.txd [*5])
      else $error("start bit too short");
   rd_hold_a: assert property (!$stable(ahbRsp.hrdata) |-> rdSeen)
      else $error("read data changed without a read");
   rd_upper_a: assert property (s_rd |=> ahbRsp.hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   bus_okay_a: assert property (ahbRsp.hreadyout && !ahbRsp.hresp)
      else $error("bus answer not ready and okay");
   unmapped_a: assert property (s_rd ##0 ahbReq.haddr[31:10] != 22'h0
      |=> ahbRsp.hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind msp_uart msp_uart_chk chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .ahbReq(ahbReq), .ahbRsp(ahbRsp), .t1Overflow(t1Overflow),
   .rxdIn(rxdIn), .serOut(serOut));

//--- verif/msp_remote.sv
// Purpose: remote serial device sending frames or shift-mode bytes
// Assumes: 32 core clocks per frame bit, as the bench configures every asynchronous mode
// Notes  : the line rests high between frames
`timescale 1ns/1ps
module msp_remote (
   // clock
   input  wire logic sys_clk,
   // shift clock from the port in shift mode
   input  wire logic sclk,
   // line to the receive pin
   output logic      rxd
);
   initial rxd = 1'b1;
   // frame bits go out index 0 first: start, data LSB first, ninth, stop
   task send(input logic [10:0] frm);
      for (int i = 0; i < 11; i++) begin
         @(posedge sys_clk);
         rxd <= frm[i];
         repeat (31) @(posedge sys_clk);
      end
   endtask
   // shift mode: bit 0 first, next bit after each rising shift clock
   task shift_byte(input logic [7:0] b);
      rxd <= b[0];
      for (int i = 1; i < 9; i++) begin
         @(posedge sclk);
         rxd <= (i < 8) ? b[i] : 1'b1;
      end
   endtask
endmodule

//--- verif/tb_top.sv
// Purpose: self-checking bench of the serial port
// Assumes: zero wait state register bus, remote at 32 clocks per bit
// Notes  : every asynchronous mode is set so one bit lasts 32 core clocks; shift mode bits last 12
`timescale 1ns/1ps
`include "msp_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   import msp_pkg::*;
   localparam logic [31:0] AD_CTRL = `MSP_IDX_CTRL * 4;
   localparam logic [31:0] AD_DATA = `MSP_IDX_DATA * 4;
   localparam logic [31:0] AD_RELL = `MSP_IDX_RELL * 4;
   localparam logic [31:0] AD_RELH = `MSP_IDX_RELH * 4;
   localparam logic [31:0] AD_BSEL = `MSP_IDX_BSEL * 4;
   localparam logic [31:0] AD_PWR  = `MSP_IDX_PWR * 4;
   logic         sys_clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         t1Overflow = 1'b0;
   logic         t1On = 1'b0;
   logic         rdPh = 1'b0;
   logic         txOn = 1'b0;
   msp_ahb_req_t rq = '0;
   msp_ahb_req_t ahbReq;
   msp_ahb_rsp_t ahbRsp;
   msp_ser_out_t serOut;
   logic         rxdIn;
   logic         rmtTx;
   logic [31:0]  rdQ[$];
   logic [31:0]  expRd;
   logic [10:0]  txQ[$];
   logic [10:0]  frm;
   logic [10:0]  expFrm;
   int           fail_count = 0;
   int           n_compared = 0;
   int           cyc = 0;
   always #2 sys_clk = ~sys_clk;
   // the single slave's hreadyout is the bus hready
   always_comb begin
      ahbReq = rq;
      ahbReq.hready = ahbRsp.hreadyout;
   end
   // two-way pin: the port drives it only while its enable is low
   assign rxdIn = serOut.rxdOe_n ? rmtTx : serOut.rxdOut;
   // overflow pulse every second clock gives a 2-clock tick
   always @(posedge sys_clk) t1Overflow <= t1On & ~t1Overflow;
   msp_uart dut (.sys_clk(sys_clk), .rst_n(rst_n), .ahbReq(ahbReq),
      .ahbRsp(ahbRsp), .t1Overflow(t1Overflow), .rxdIn(rxdIn),
      .serOut(serOut));
   msp_remote rmt (.sys_clk(sys_clk), .sclk(serOut.txd), .rxd(rmtTx));
   // one single transfer; a read notes its expected byte
   task bus(input logic [31:0] a, input logic w, input logic [7:0] d);
      if (!w) rdQ.push_back({24'h0, d});
      rq.hsel <= 1'b1;
      rq.haddr <= a;
      rq.htrans <= 2'b10;
      rq.hwrite <= w;
      rq.hsize <= 3'b010;
      do @(posedge sys_clk); while (ahbRsp.hreadyout !== 1'b1);
      rq.htrans <= 2'b00;
      rq.hwdata <= {24'h0, d};
      rdPh <= !w;
      do @(posedge sys_clk); while (ahbRsp.hreadyout !== 1'b1);
      rdPh <= 1'b0;
   endtask
   task finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // read data is taken at the data-phase edge
   always @(posedge sys_clk) begin
      if (rdPh && ahbRsp.hreadyout && rdQ.size() > 0) begin
         expRd = rdQ.pop_front();
         `CHK("hrdata", expRd, ahbRsp.hrdata)
      end
   end
   // samples each transmitted bit near its middle
   always begin
      @(negedge serOut.txd iff txOn);
      repeat (16) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         frm[i] = serOut.txd;
         repeat (32) @(posedge sys_clk);
      end
      expFrm = txQ.pop_front();
      `CHK("frame", expFrm, frm)
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      logic [7:0] d;
      logic [7:0] c;
      logic       nb;
      void'($urandom(79));
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(AD_CTRL, 1'b0, 8'h00);
      bus(AD_RELL, 1'b0, 8'hd9);
      bus(AD_RELH, 1'b0, 8'h03);
      bus(AD_BSEL, 1'b0, 8'h00);
      bus(32'h8000_0260, 1'b0, 8'h00);
      bus(AD_PWR, 1'b1, 8'h80);
      bus(AD_RELL, 1'b1, 8'hff);
      bus(AD_RELH, 1'b1, 8'hff);
      bus(AD_RELH, 1'b0, 8'hff);
      // shift mode: data bit in the low half of each 12-clock bit
      d = 8'($urandom);
      bus(AD_DATA, 1'b1, d);
      repeat (3) @(posedge sys_clk);
      for (int k = 0; k < 8; k++) begin
         `CHK("rxdOut", d[k], serOut.rxdOut)
         repeat (12) @(posedge sys_clk);
      end
      bus(AD_CTRL, 1'b0, 8'h02);
      bus(AD_DATA, 1'b0, 8'h00);
      // shift mode reception: the port clocks, the remote drives data
      d = 8'($urandom);
      fork
         rmt.shift_byte(d);
         bus(AD_CTRL, 1'b1, 8'h10);
      join
      repeat (8) @(posedge sys_clk);
      bus(AD_CTRL, 1'b0, 8'h11);
      bus(AD_DATA, 1'b0, d);
      // asynchronous modes, each set up for 32 clocks per bit
      for (int m = 1; m < 4; m++) begin
         t1On <= (m == 1);
         bus(AD_BSEL, 1'b1, (m == 3) ? 8'h80 : 8'h00);
         nb = 1'($urandom);
         d = 8'($urandom);
         c = {m[1:0], 2'b01, nb, 3'b000};
         bus(AD_CTRL, 1'b1, c);
         txQ.push_back({1'b1, (m == 1) | nb, d, 1'b0});
         txOn <= 1'b1;
         bus(AD_DATA, 1'b1, d);
         repeat (380) @(posedge sys_clk);
         txOn <= 1'b0;
         bus(AD_CTRL, 1'b0, c | 8'h02);
         nb = 1'($urandom);
         d = 8'($urandom);
         rmt.send({1'b1, (m == 1) | nb, d, 1'b0});
         bus(AD_CTRL, 1'b0, c | {5'h0, (m == 1) | nb, 2'h3});
         bus(AD_DATA, 1'b0, d);
      end
      // multiprocessor filter, then reception disabled (mode 2)
      for (int k = 0; k < 3; k++) begin
         c = (k == 2) ? 8'h80 : 8'hb0;
         bus(AD_CTRL, 1'b1, c);
         d = 8'($urandom);
         rmt.send({1'b1, k == 1, d, 1'b0});
         bus(AD_CTRL, 1'b0, (k == 1) ? 8'hb5 : c);
      end
      @(posedge sys_clk);
      finish_test();
   end
endmodule
